// ==== src/autoneg_consts.svh ====
/*
 * Register offsets, bank numbers, field positions, command values and
 * timing for the negotiation set-up controller.
 * Assumes a 100 MHz ref_clk and a device with banked MAC registers and
 * an internal PHY reached by serial management frames.
 */
`ifndef AUTONEG_CONSTS_SVH
`define AUTONEG_CONSTS_SVH

// Clock and times
`define CLK_MHZ            100
`define T_POWER_WAIT_MS    50
`define T_NEG_WAIT_MS      1500
`define MDC_HALF_CYCLES    8'd20

// MAC banks and offsets
`define BANK_0             2'h0
`define BANK_2             2'h2
`define OFS_TCR_XMIT       4'h0
`define OFS_RX_CTRL        4'h4
`define OFS_RX_PHY_CTRL    4'ha
`define OFS_IRQ_MASK       4'hd

// MAC values and bits
`define RX_SOFT_RST_SET    16'h8000
`define RX_SOFT_RST_CLR    16'h0000
`define TCR_FULL_SWITCH    15
`define RPC_SPEED_BIT      13
`define RPC_DUPLEX_BIT     12
`define RPC_NEGOTIATE_BIT  11
`define IRQ_MGMT_MASK_BIT  7

// PHY registers
`define PHY_ADDR           5'h00
`define PHY_REG_CTRL       5'h00
`define PHY_REG_STAT       5'h01
`define PHY_REG_ADV        5'h04
`define PHY_REG_STAT_OUT   5'h12
`define PHY_REG_MASK       5'h13

// PHY values and bits
`define PHY_CTRL_RESET     16'h8000
`define PHY_CTRL_UNISO     16'h1000
`define PHY_CTRL_RESTART   16'h3200
`define PHY_CTRL_SPEED_BIT 13
`define PHY_CTRL_NEG_BIT   12
`define PHY_CTRL_DUPLEX_SELECT_BIT  8
`define ADV_SELECTOR       16'h0001
`define ADV_FAST_FULL_BIT  8
`define ADV_FAST_HALF_BIT  7
`define ADV_SLOW_FULL_BIT  6
`define ADV_SLOW_HALF_BIT  5
`define STAT_NEG_DONE_BIT  5
`define STAT_LINK_BIT      2
`define SOUT_LINK_FAIL_BIT 14
`define SOUT_SPEED_BIT     7
`define SOUT_DUPLEX_BIT    6
`define PHY_MASK_VALUE     16'h3fff

// Management frame layout
`define MDIO_FRAME_BITS    7'd64
`define MDIO_TA_BIT        7'd46
`define MDIO_DATA_BIT      7'd48
`define MDIO_OP_WRITE      2'b01
`define MDIO_OP_READ       2'b10

`endif

// ==== src/autoneg_pkg.sv ====
/*
 * Types shared by the negotiation set-up controller, its port checker,
 * the device model and the bench.
 * Assumes autoneg_consts.svh holds every number.
 */
package autoneg_pkg;

   typedef struct packed {
      logic [1:0]  bank;
      logic [3:0]  offset;
      logic [15:0] data;
   } mac_write_s;

   typedef struct packed {
      logic        manual;
      logic        via_phy;
      logic        speed_fast;
      logic        full;
   } link_target_s;

   typedef struct packed {
      logic        linked;
      logic        speed_fast;
      logic        full;
      logic        failed;
   } link_result_s;

   typedef enum logic [4:0] {
      S_IDLE      = 5'b00000,
      S_WAIT_PWR  = 5'b00001,
      S_SRST_SET  = 5'b00010,
      S_SRST_CLR  = 5'b00011,
      S_WAIT_RST  = 5'b00100,
      S_RPC_WR    = 5'b00101,
      S_IRQ_WR    = 5'b00110,
      S_PMASK_WR  = 5'b00111,
      S_ADV_WR    = 5'b01000,
      S_PHY_RST   = 5'b01001,
      S_PHY_UNISO = 5'b01010,
      S_WAIT_NEG  = 5'b01011,
      S_STAT_RD   = 5'b01100,
      S_SOUT_RD   = 5'b01101,
      S_TCR_WR    = 5'b01110,
      S_RESTART   = 5'b01111,
      S_LINKED    = 5'b10000,
      S_FAIL_RD   = 5'b10001,
      S_MAC_XFER  = 5'b10010,
      S_PHY_XFER  = 5'b10011,
      S_MAN_PHY   = 5'b10100
   } seq_state_e;

endpackage

// ==== src/mdio_master.sv ====
/*
 * Serial management frame engine: one full frame per request.
 * Assumes the PHY samples on the rising edge of mdc and that the
 * pin logic resolves mdio from mdio_o and mdio_oe.
 */
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_consts.svh"

module mdio_master (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Request
   input  wire logic        start,
   input  wire logic        read,
   input  wire logic [4:0]  reg_addr,
   input  wire logic [15:0] wdata,
   output logic             busy,
   output logic             done,
   output logic [15:0]      rdata,
   // Management pins
   output logic             mdc,
   output logic             mdio_o,
   output logic             mdio_oe,
   input  wire logic        mdio_i
);

   logic [63:0] shift_r;
   logic [6:0]  bit_r;
   logic [7:0]  div_r;
   logic        rd_r;
   logic        tick;

   assign tick = (div_r == `MDC_HALF_CYCLES - 8'd1);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         div_r <= 8'h00;
      end else if (!busy || tick) begin
         div_r <= 8'h00;
      end else begin
         div_r <= div_r + 8'd1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         busy    <= 1'b0;
         done    <= 1'b0;
         rdata   <= 16'h0000;
         mdc     <= 1'b0;
         mdio_o  <= 1'b0;
         mdio_oe <= 1'b0;
         shift_r <= 64'h0000_0000_0000_0000;
         bit_r   <= 7'h00;
         rd_r    <= 1'b0;
      end else begin
         done <= 1'b0;
         if (!busy) begin
            if (start) begin
               shift_r <= {32'hffff_ffff, 2'b01,
                           read ? `MDIO_OP_READ : `MDIO_OP_WRITE,
                           `PHY_ADDR, reg_addr, 2'b10, wdata};
               mdio_o  <= 1'b1;
               mdio_oe <= 1'b1;
               busy    <= 1'b1;
               rd_r    <= read;
               bit_r   <= 7'h00;
               mdc     <= 1'b0;
            end
         end else if (tick) begin
            if (!mdc) begin
               mdc <= 1'b1;
               if (rd_r && bit_r >= `MDIO_DATA_BIT) begin
                  rdata <= {rdata[14:0], mdio_i};
               end
            end else begin
               mdc <= 1'b0;
               if (bit_r == `MDIO_FRAME_BITS - 7'd1) begin
                  busy    <= 1'b0;
                  done    <= 1'b1;
                  mdio_oe <= 1'b0;
                  mdio_o  <= 1'b0;
               end else begin
                  bit_r   <= bit_r + 7'd1;
                  shift_r <= {shift_r[62:0], 1'b0};
                  mdio_o  <= shift_r[62];
                  // Release the line from turnaround on for reads
                  mdio_oe <= !(rd_r && (bit_r + 7'd1 >= `MDIO_TA_BIT));
               end
            end
         end
      end
   end

endmodule
`default_nettype wire

// ==== src/autoneg_setup_host.sv ====
/*
 * Host-side sequencer bringing an Ethernet MAC with internal PHY up in
 * negotiated or manual speed and duplex, and recovering from link loss on negotiated links.
 * Assumes a MAC register write port that acknowledges each write and a
 * PHY reached by the management pins; the device irq is a level.
 */
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_consts.svh"

module autoneg_setup_host #(
   parameter int unsigned POWER_WAIT_CYC =
      `T_POWER_WAIT_MS * 1000 * `CLK_MHZ,
   parameter int unsigned NEG_WAIT_CYC =
      `T_NEG_WAIT_MS * 1000 * `CLK_MHZ,
   parameter logic [7:0] RETRY_MAX = 8'd3
) (
   // Clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     rst_n,
   // User orders
   input  wire logic                     start,
   input  wire logic                     resumed,
   input  wire autoneg_pkg::link_target_s target,
   output autoneg_pkg::link_result_s     result,
   output logic                          busy,
   // Device MAC register writes
   output logic                          mac_wr,
   output autoneg_pkg::mac_write_s       mac_req,
   input  wire logic                     mac_ack,
   // Device interrupt
   input  wire logic                     dev_irq,
   // PHY management pins
   output logic                          mdc,
   output logic                          mdio_o,
   output logic                          mdio_oe,
   input  wire logic                     mdio_i
);

   autoneg_pkg::seq_state_e     state_r;
   autoneg_pkg::seq_state_e     ret_r;
   autoneg_pkg::link_target_s   tgt_r;
   logic [31:0]                 timer_r;
   logic [7:0]                  retry_r;
   logic                        was_slow_r;
   logic                        phy_start_r;
   logic                        phy_read_r;
   logic [4:0]                  phy_reg_r;
   logic [15:0]                 phy_wdata_r;
   logic                        phy_busy;
   logic                        phy_done;
   logic [15:0]                 phy_rdata;
   logic [15:0]                 adv_val;
   logic [15:0]                 rpc_val;
   logic [15:0]                 man_phy_val;

   mdio_master u_mdio (
      .ref_clk  (ref_clk),
      .rst_n    (rst_n),
      .start    (phy_start_r),
      .read     (phy_read_r),
      .reg_addr (phy_reg_r),
      .wdata    (phy_wdata_r),
      .busy     (phy_busy),
      .done     (phy_done),
      .rdata    (phy_rdata),
      .mdc      (mdc),
      .mdio_o   (mdio_o),
      .mdio_oe  (mdio_oe),
      .mdio_i   (mdio_i)
   );

   // Advertisement per target: each lower target drops the faster ones
   always_comb begin
      adv_val = `ADV_SELECTOR;
      adv_val[`ADV_SLOW_HALF_BIT] = 1'b1;
      adv_val[`ADV_SLOW_FULL_BIT] = tgt_r.speed_fast | tgt_r.full;
      adv_val[`ADV_FAST_HALF_BIT] = tgt_r.speed_fast;
      adv_val[`ADV_FAST_FULL_BIT] = tgt_r.speed_fast & tgt_r.full;
   end

   // MAC-side control word: negotiate unless manual without PHY; manual bits whenever manual
   always_comb begin
      rpc_val = 16'h0000;
      rpc_val[`RPC_NEGOTIATE_BIT] = !tgt_r.manual || tgt_r.via_phy;
      rpc_val[`RPC_SPEED_BIT] = tgt_r.manual && tgt_r.speed_fast;
      rpc_val[`RPC_DUPLEX_BIT] = tgt_r.manual && tgt_r.full;
   end

   // Manual PHY control with its negotiate enable off
   always_comb begin
      man_phy_val = 16'h0000;
      man_phy_val[`PHY_CTRL_SPEED_BIT] = tgt_r.speed_fast;
      man_phy_val[`PHY_CTRL_DUPLEX_SELECT_BIT] = tgt_r.full;
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_r     <= autoneg_pkg::S_IDLE;
         ret_r       <= autoneg_pkg::S_IDLE;
         tgt_r       <= '0;
         timer_r     <= 32'h0000_0000;
         retry_r     <= 8'h00;
         was_slow_r  <= 1'b0;
         phy_start_r <= 1'b0;
         phy_read_r  <= 1'b0;
         phy_reg_r   <= 5'h00;
         phy_wdata_r <= 16'h0000;
         mac_wr      <= 1'b0;
         mac_req     <= '0;
         result      <= '0;
         busy        <= 1'b0;
      end else begin
         phy_start_r <= 1'b0;
         mac_wr      <= 1'b0;
         case (state_r)
            autoneg_pkg::S_IDLE: begin
               if (start) begin
                  tgt_r   <= target;
                  result  <= '0;
                  busy    <= 1'b1;
                  timer_r <= POWER_WAIT_CYC;
                  state_r <= autoneg_pkg::S_WAIT_PWR;
               end
            end
            autoneg_pkg::S_WAIT_PWR: begin
               if (timer_r <= 32'd1) begin
                  mac_req <= '{`BANK_0, `OFS_RX_CTRL, `RX_SOFT_RST_SET};
                  mac_wr  <= 1'b1;
                  ret_r   <= autoneg_pkg::S_SRST_CLR;
                  state_r <= autoneg_pkg::S_MAC_XFER;
               end else begin
                  timer_r <= timer_r - 32'd1;
               end
            end
            autoneg_pkg::S_SRST_CLR: begin
               mac_req <= '{`BANK_0, `OFS_RX_CTRL, `RX_SOFT_RST_CLR};
               mac_wr  <= 1'b1;
               timer_r <= POWER_WAIT_CYC;
               ret_r   <= autoneg_pkg::S_WAIT_RST;
               state_r <= autoneg_pkg::S_MAC_XFER;
            end
            autoneg_pkg::S_WAIT_RST: begin
               if (timer_r <= 32'd1) begin
                  state_r <= autoneg_pkg::S_RPC_WR;
               end else begin
                  timer_r <= timer_r - 32'd1;
               end
            end
            autoneg_pkg::S_RPC_WR: begin
               mac_req <= '{`BANK_0, `OFS_RX_PHY_CTRL, rpc_val};
               mac_wr  <= 1'b1;
               ret_r   <= autoneg_pkg::S_IRQ_WR;
               state_r <= autoneg_pkg::S_MAC_XFER;
            end
            autoneg_pkg::S_IRQ_WR: begin
               mac_req <= '{`BANK_2, `OFS_IRQ_MASK,
                            16'h0001 << `IRQ_MGMT_MASK_BIT};
               mac_wr  <= 1'b1;
               ret_r   <= autoneg_pkg::S_PMASK_WR;
               state_r <= autoneg_pkg::S_MAC_XFER;
            end
            autoneg_pkg::S_PMASK_WR: begin
               // Clears only the global and link-fail masks
               phy_reg_r   <= `PHY_REG_MASK;
               phy_wdata_r <= `PHY_MASK_VALUE;
               phy_read_r  <= 1'b0;
               phy_start_r <= 1'b1;
               ret_r       <= tgt_r.manual ? autoneg_pkg::S_MAN_PHY
                                           : autoneg_pkg::S_PHY_RST;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_ADV_WR: begin
               // After the PHY reset, which restores the defaults
               phy_reg_r   <= `PHY_REG_ADV;
               phy_wdata_r <= adv_val;
               phy_start_r <= 1'b1;
               ret_r       <= autoneg_pkg::S_PHY_UNISO;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_PHY_RST: begin
               phy_reg_r   <= `PHY_REG_CTRL;
               phy_wdata_r <= `PHY_CTRL_RESET;
               phy_read_r  <= 1'b0;
               phy_start_r <= 1'b1;
               ret_r       <= autoneg_pkg::S_ADV_WR;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_PHY_UNISO: begin
               // PHY comes out of reset isolated; this lets it pulse
               phy_reg_r   <= `PHY_REG_CTRL;
               phy_wdata_r <= `PHY_CTRL_UNISO;
               phy_start_r <= 1'b1;
               timer_r     <= NEG_WAIT_CYC;
               retry_r     <= 8'h00;
               ret_r       <= autoneg_pkg::S_WAIT_NEG;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_MAN_PHY: begin
               // Also drops isolation, which a manual link needs too
               phy_reg_r   <= `PHY_REG_CTRL;
               phy_wdata_r <= man_phy_val;
               phy_start_r <= 1'b1;
               ret_r       <= autoneg_pkg::S_TCR_WR;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_WAIT_NEG: begin
               if (timer_r <= 32'd1) begin
                  state_r <= autoneg_pkg::S_STAT_RD;
               end else begin
                  timer_r <= timer_r - 32'd1;
               end
            end
            autoneg_pkg::S_STAT_RD: begin
               phy_reg_r   <= `PHY_REG_STAT;
               phy_read_r  <= 1'b1;
               phy_start_r <= 1'b1;
               ret_r       <= autoneg_pkg::S_SOUT_RD;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_SOUT_RD: begin
               if (phy_rdata[`STAT_NEG_DONE_BIT]
                   && phy_rdata[`STAT_LINK_BIT]) begin
                  phy_reg_r   <= `PHY_REG_STAT_OUT;
                  phy_read_r  <= 1'b1;
                  phy_start_r <= 1'b1;
                  ret_r       <= autoneg_pkg::S_TCR_WR;
                  state_r     <= autoneg_pkg::S_PHY_XFER;
               end else if (retry_r < RETRY_MAX) begin
                  state_r <= autoneg_pkg::S_RESTART;
               end else begin
                  result  <= '{1'b0, 1'b0, 1'b0, 1'b1};
                  busy    <= 1'b0;
                  state_r <= autoneg_pkg::S_IDLE;
               end
            end
            autoneg_pkg::S_RESTART: begin
               phy_reg_r   <= `PHY_REG_CTRL;
               phy_wdata_r <= `PHY_CTRL_RESTART;
               phy_read_r  <= 1'b0;
               phy_start_r <= 1'b1;
               retry_r     <= retry_r + 8'd1;
               timer_r     <= NEG_WAIT_CYC;
               ret_r       <= autoneg_pkg::S_WAIT_NEG;
               state_r     <= autoneg_pkg::S_PHY_XFER;
            end
            autoneg_pkg::S_TCR_WR: begin
               // Whole-word write; other transmit bits are left zero
               if (!tgt_r.manual) begin
                  result <= '{1'b1, phy_rdata[`SOUT_SPEED_BIT],
                              phy_rdata[`SOUT_DUPLEX_BIT], 1'b0};
                  was_slow_r <= !phy_rdata[`SOUT_SPEED_BIT];
               end else begin
                  result <= '{1'b1, tgt_r.speed_fast, tgt_r.full, 1'b0};
               end
               mac_req <= '{`BANK_0, `OFS_TCR_XMIT,
                            16'(tgt_r.manual ? tgt_r.full
                                : phy_rdata[`SOUT_DUPLEX_BIT])
                            << `TCR_FULL_SWITCH};
               mac_wr  <= 1'b1;
               ret_r   <= autoneg_pkg::S_LINKED;
               state_r <= autoneg_pkg::S_MAC_XFER;
            end
            autoneg_pkg::S_LINKED: begin
               busy <= 1'b0;
               if (start) begin
                  state_r <= autoneg_pkg::S_IDLE;
               end else if (resumed) begin
                  busy    <= 1'b1;
                  timer_r <= POWER_WAIT_CYC;
                  state_r <= autoneg_pkg::S_WAIT_RST;
               end else if (dev_irq && !tgt_r.manual) begin
                  // Reading the status output also clears the event
                  phy_reg_r   <= `PHY_REG_STAT_OUT;
                  phy_read_r  <= 1'b1;
                  phy_start_r <= 1'b1;
                  busy        <= 1'b1;
                  ret_r       <= autoneg_pkg::S_FAIL_RD;
                  state_r     <= autoneg_pkg::S_PHY_XFER;
               end
            end
            autoneg_pkg::S_FAIL_RD: begin
               if (!phy_rdata[`SOUT_LINK_FAIL_BIT]) begin
                  state_r <= autoneg_pkg::S_LINKED;
               end else if (was_slow_r) begin
                  result.linked <= 1'b0;
                  state_r <= autoneg_pkg::S_PHY_RST;
               end else begin
                  result.linked <= 1'b0;
                  timer_r <= NEG_WAIT_CYC;
                  retry_r <= 8'h00;
                  state_r <= autoneg_pkg::S_WAIT_NEG;
               end
            end
            autoneg_pkg::S_MAC_XFER: begin
               if (mac_ack) begin
                  state_r <= ret_r;
               end
            end
            autoneg_pkg::S_PHY_XFER: begin
               if (phy_done) begin
                  state_r <= ret_r;
               end
            end
            default: begin
               state_r <= autoneg_pkg::S_IDLE;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// ==== dv/autoneg_setup_chk.sv ====
/* Port checker for the negotiation set-up host.
   Assumes the constants header is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "autoneg_consts.svh"
module autoneg_setup_chk (
   // Clock and reset
   input wire logic                      ref_clk,
   input wire logic                      rst_n,
   // Watched ports
   input wire logic                      start,
   input wire logic                      busy,
   input wire autoneg_pkg::link_result_s result,
   input wire logic                      mac_wr,
   input wire autoneg_pkg::mac_write_s   mac_req,
   input wire logic                      mac_ack,
   input wire logic                      dev_irq,
   input wire logic                      mdc,
   input wire logic                      mdio_o,
   input wire logic                      mdio_oe
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence srst_set;
      mac_wr && mac_req == {`BANK_0, `OFS_RX_CTRL, `RX_SOFT_RST_SET};
   endsequence
   sequence srst_clr;
      mac_wr && mac_req == {`BANK_0, `OFS_RX_CTRL, `RX_SOFT_RST_CLR};
   endsequence
   a_srst_pair: assert property (srst_set |-> ##[2:40] srst_clr)
      else $error("soft reset left set");
   a_wr_pulse: assert property (mac_wr |=> !mac_wr)
      else $error("write strobe too long");
   a_req_holds: assert property (!mac_wr |-> $stable(mac_req))
      else $error("request moved without strobe");
   a_ack_gap: assert property (mac_ack |=> !mac_wr)
      else $error("write right after ack");
   a_mdc_half: assert property ($rose(mdc) |-> mdc[*8] ##12 mdc ##1 !mdc)
      else $error("management clock half period wrong");
   a_frame_lead: assert property ($rose(mdio_oe) |-> mdio_o)
      else $error("frame starts without preamble");
   a_start_taken: assert property (start && !busy && result.failed
      |-> ##[1:2] busy)
      else $error("start ignored in idle");
   a_dpx_follows: assert property ($rose(result.linked) |->
      mac_req.data[15] == result.full && mac_req.offset == `OFS_TCR_XMIT)
      else $error("MAC duplex differs from result");
   a_irq_served: assert property (dev_irq && result.linked && !busy
      |-> ##[1:40] (busy || mdc))
      else $error("link event not served");
endmodule
bind autoneg_setup_host autoneg_setup_chk i_chk (.ref_clk, .rst_n, .start,
   .busy, .result, .mac_wr, .mac_req, .mac_ack, .dev_irq, .mdc, .mdio_o,
   .mdio_oe);
`default_nettype wire

// ==== dv/dev_model.sv ====
/* Device model: MAC registers, PHY registers on management frames,
   negotiation with a partner of all four abilities.
   Assumes frames are whole and management data has a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module dev_model #(parameter int NEG_CYC = 100) (
   // Clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    rst_n,
   // MAC register port
   input  wire logic                    mac_wr,
   input  wire autoneg_pkg::mac_write_s mac_req,
   output logic                         mac_ack,
   output logic                         dev_irq,
   // Management pins
   input  wire logic                    mdc,
   input  wire logic                    mdio_o,
   input  wire logic                    mdio_oe,
   output logic                         mdio_i,
   // Test knobs
   input  wire logic                    peer_on,
   input  wire logic                    cut
);
   localparam logic [3:0] PEER = 4'hf;
   logic [15:0] tcr_r, rpc_r, imask_r, ctrl_r, adv_r, msk_r, sh_r, rv, wd;
   logic [3:0]  rem_r, c;
   logic        mdc_r, rd_r, drv_r, bit_r, done_r, link_r, fail_r, fast_r;
   logic        full_r, w;
   logic [4:0]  ra_r;
   logic [5:0]  n_r;
   int          neg_r, rst_cnt_r, rs_cnt_r;
   assign w = mdio_oe ? mdio_o : (drv_r ? bit_r : 1'b1);
   assign mdio_i = w;
   assign wd = {sh_r[14:0], w};
   assign c = adv_r[8:5] & PEER;
   assign dev_irq = fail_r & ~msk_r[15] & ~msk_r[14] & imask_r[7];
   always_comb begin
      case (ra_r)
         5'h00: rv = ctrl_r;
         5'h01: rv = {10'h000, done_r, 1'b0, peer_on, link_r, 2'h0};
         5'h04: rv = adv_r;
         5'h12: rv = {1'b0, fail_r, 6'h00, fast_r, full_r, 6'h00};
         default: rv = 16'h0000;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      mac_ack <= mac_wr & rst_n;
      if (!rst_n) begin
         tcr_r <= '0;
         rpc_r <= '0;
         imask_r <= '0;
      end else if (mac_wr && mac_req.offset == 4'hd) imask_r <= mac_req.data;
      else if (mac_wr && mac_req.offset == 4'h0) tcr_r <= mac_req.data;
      else if (mac_wr && mac_req.offset == 4'ha) rpc_r <= mac_req.data;
      else if (mac_wr && mac_req.offset == 4'h4 && mac_req.data[15]) begin
         rpc_r <= '0;
         tcr_r <= '0;
      end
   end
   always_ff @(posedge ref_clk) begin
      mdc_r <= mdc;
      if (!rst_n) begin
         {n_r, drv_r, done_r, link_r, fail_r, fast_r, full_r} <= '0;
         ctrl_r <= 16'h0400;
         adv_r <= 16'h01e1;
         msk_r <= '0;
         {neg_r, rst_cnt_r, rs_cnt_r} <= '0;
      end else begin
         if (neg_r > 1) neg_r <= neg_r - 1;
         if (neg_r == 1 && peer_on) begin
            neg_r <= 0;
            {done_r, link_r, rem_r} <= {2'b11, PEER};
            fast_r <= c[3] | c[2];
            full_r <= c[3] | (~c[2] & c[1]);
         end
         if (cut) begin
            {fail_r, link_r, done_r} <= 3'b100;
            neg_r <= NEG_CYC;
         end
         if (mdc & ~mdc_r) begin
            n_r <= n_r + 6'h01;
            sh_r <= wd;
            if (n_r == 6'h23) rd_r <= ~w;
            if (n_r == 6'h2d) ra_r <= wd[4:0];
            drv_r <= rd_r && n_r >= 6'h2f && n_r < 6'h3f;
            bit_r <= rv[4'(6'h3e - n_r)];
            if (n_r == 6'h3f && rd_r && ra_r == 5'h12) fail_r <= 1'b0;
            if (n_r == 6'h3f && !rd_r && ra_r == 5'h00) begin
               if (wd[15]) begin
                  {ctrl_r, adv_r} <= {16'h0400, 16'h01e1};
                  {neg_r, done_r, link_r} <= '0;
                  rst_cnt_r <= rst_cnt_r + 1;
               end else begin
                  ctrl_r <= wd;
                  if (wd[12] & ~wd[10] & rpc_r[11]) begin
                     neg_r <= NEG_CYC;
                     {done_r, link_r} <= '0;
                  end
                  if (wd[9]) rs_cnt_r <= rs_cnt_r + 1;
               end
            end
            if (n_r == 6'h3f && !rd_r && ra_r == 5'h04) adv_r <= wd;
            if (n_r == 6'h3f && !rd_r && ra_r == 5'h13) msk_r <= wd;
         end
      end
   end
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
/* Bench for the negotiation set-up host against the device model.
   Assumes shortened waits; run stays near 90k cycles. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk = 0, rst_n = 0, start = 0, resumed = 0, cut = 0;
   logic peer_on = 1, busy, mac_wr, mac_ack, dev_irq, mdc, mdio_o;
   logic mdio_oe, mdio_i;
   autoneg_pkg::link_target_s target = '0;
   autoneg_pkg::link_result_s result;
   autoneg_pkg::mac_write_s   mac_req;
   int fails = 0, samples_checked = 0, cyc = 0, n;
   autoneg_setup_host #(.POWER_WAIT_CYC(50), .NEG_WAIT_CYC(200),
      .RETRY_MAX(8'h01)) i_dut (.ref_clk, .rst_n, .start, .resumed, .target,
      .result, .busy, .mac_wr, .mac_req, .mac_ack, .dev_irq, .mdc, .mdio_o,
      .mdio_oe, .mdio_i);
   dev_model #(.NEG_CYC(100)) i_dev (.ref_clk, .rst_n, .mac_wr, .mac_req,
      .mac_ack, .dev_irq, .mdc, .mdio_o, .mdio_oe, .mdio_i, .peer_on, .cut);
   initial forever #5 ref_clk = ~ref_clk;
   task automatic give_verdict;
      if (fails == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
      end
   endtask
   task automatic settle;
      while (!(result.linked !== 1'bx && busy === 1'b0)) begin
         @(posedge ref_clk);
         #1;
      end
   endtask
   task automatic run(input logic [3:0] t);
      target <= t;
      start <= 1'b1;
      @(posedge ref_clk);
      start <= 1'b0;
      @(posedge ref_clk);
      #1;
      // A start in the linked state only drops back to idle
      if (busy !== 1'b1) begin
         @(posedge ref_clk);
         start <= 1'b1;
         @(posedge ref_clk);
         start <= 1'b0;
         @(posedge ref_clk);
      end
      settle();
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 110000) begin
         fails++;
         $display("unexpected at %0t: run hung", $time);
         give_verdict();
      end
   end
   initial begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      run(4'b0001);
      check(i_dev.adv_r, 16'h0061);
      check(i_dev.rpc_r & 16'h0800, 16'h0800);
      check(i_dev.tcr_r, 16'h8000);
      check(result, 4'b1010);
      check(i_dev.msk_r, 16'h3fff);
      check(i_dev.imask_r, 16'h0080);
      n = i_dev.rst_cnt_r;
      cut <= 1'b1;
      @(posedge ref_clk);
      cut <= 1'b0;
      while (result.linked !== 1'b0) @(posedge ref_clk);
      while (!(result.linked === 1'b1 && busy === 1'b0)) @(posedge ref_clk);
      #1;
      check(result, 4'b1010);
      check(16'(i_dev.rst_cnt_r - n), 16'h0001);
      @(posedge ref_clk);
      resumed <= 1'b1;
      @(posedge ref_clk);
      resumed <= 1'b0;
      while (busy !== 1'b1) @(posedge ref_clk);
      settle();
      check(16'(i_dev.rst_cnt_r - n), 16'h0002);
      check(result, 4'b1010);
      run(4'b0011);
      check(i_dev.adv_r, 16'h01e1);
      check(result, 4'b1110);
      peer_on <= 1'b0;
      n = i_dev.rs_cnt_r;
      run(4'b0010);
      check(i_dev.adv_r, 16'h00e1);
      check({result.linked, result.failed}, 16'h0001);
      check(16'(i_dev.rs_cnt_r - n), 16'h0001);
      peer_on <= 1'b1;
      run(4'b1110);
      check(i_dev.ctrl_r, 16'h2000);
      check(i_dev.rpc_r & 16'h3800, 16'h2800);
      check(i_dev.tcr_r, 16'h0000);
      run(4'b1001);
      check(i_dev.rpc_r & 16'h3800, 16'h1000);
      check(i_dev.tcr_r, 16'h8000);
      give_verdict();
   end
endmodule
`default_nettype wire
